/* File: src/cfs_pkg.sv */
// Purpose: Shared constants for the converter fault supervisor
// Assumes: sys_clk at 100 MHz
// Notes:   Times are kept in ns; cycle counts derive from them
package cfs_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SYNC_LATE_NS   = 1000;
  localparam int SYNC_LATE_CYC  = (SYNC_LATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_TIME_NS     = 4000000;
  localparam int SS_CYC         = SS_TIME_NS / CLK_PERIOD_NS;
  localparam int SW_PERIOD_NS   = 2000;
  localparam int SW_PERIOD_CYC  = SW_PERIOD_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Fault counting
  localparam int OC_CONSEC      = 3;
  localparam int HICCUP_SS_MULT = 7;
  localparam int OC_CNT_W       = 2;
  localparam int SYNC_CNT_W     = 16;
  localparam int TMR_W          = 24;
  localparam logic [OC_CNT_W-1:0] OC_CNT_RESET = 2'h0;
  // ==========================================================
  // Supervisor states
  typedef enum logic [2:0] {
    CFS_SOFTSTART,
    CFS_RUN,
    CFS_OV_DISCHARGE,
    CFS_HICCUP,
    CFS_OT_HALT,
    CFS_SYNC_LOST
  } cfs_state_t;
endpackage

/* File: src/cfs_sync2.sv */
// Purpose: Two-flop synchroniser for a bundle of async pins
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module cfs_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1[g]   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          stage1[g]   <= async_in[g];
          sync_out[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: src/cfs_supervisor.sv */
// Purpose: Cycle-by-cycle current limit, hiccup, OV/UV/OT and sync-loss supervision
// Assumes: Comparator and sync pins are asynchronous; pwm_on_req is on sys_clk
// Notes:   Gate outputs are registered; no dead-time shaping here
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Hold high side off while low-side current high
// - Positive and fixed negative current limits
// - Count every overcurrent cycle
// - Three consecutive overcurrent cycles enter hiccup
// - Hiccup waits seven soft-start periods, then restarts
// - Resume if clear, else hiccup again
// - High-side peak trip ends on time, counts
// - Overvoltage: low-side on, then hiccup
// - Undervoltage after soft-start: both off, hiccup
// - Over-temperature halts until indication releases
// - Late sync falling edge flags lost sync
// - Lost sync pulls share line low
module cfs_supervisor #(
  parameter int SS_CYCLES  = cfs_pkg::SS_CYC,
  parameter int PERIOD_CYC = cfs_pkg::SW_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Modulator request
  input  wire logic pwm_on_req,
  // Comparator pins
  input  wire logic ls_overcurrent,
  input  wire logic neg_current_limit,
  input  wire logic hs_peak_trip,
  input  wire logic ov_trip,
  input  wire logic uv_trip,
  input  wire logic shutdown_temperature,
  // External sync
  input  wire logic sync_enable,
  input  wire logic sync_clk_in,
  // Switch drivers
  output var  logic hs_gate,
  output var  logic ls_gate,
  // Shared phase line, open drain
  output var  logic phase_share_line_out,
  output var  logic phase_share_line_oe,
  // Status
  output var  logic soft_start_done,
  output var  logic hiccup_active,
  output var  logic lost_sync_fault
);
  localparam int HICCUP_CYC = cfs_pkg::HICCUP_SS_MULT * SS_CYCLES;
  localparam logic [cfs_pkg::TMR_W-1:0] SS_LAST = cfs_pkg::TMR_W'(SS_CYCLES - 1);
  localparam logic [cfs_pkg::TMR_W-1:0] HIC_LAST = cfs_pkg::TMR_W'(HICCUP_CYC - 1);
  localparam logic [15:0] PER_LAST = 16'(PERIOD_CYC - 1);
  localparam logic [cfs_pkg::SYNC_CNT_W:0] LATE = 17'(cfs_pkg::SYNC_LATE_CYC);
  localparam logic [cfs_pkg::OC_CNT_W-1:0] OC_LAST = cfs_pkg::OC_CNT_W'(cfs_pkg::OC_CONSEC - 1);

  // ==========================================================
  // Pin synchronisation
  logic ls_oc_s, neg_s, hs_trip_s, ov_s, uv_s, ot_s, sync_en_s, sync_s;

  cfs_sync2 #(.WIDTH(8)) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({ls_overcurrent, neg_current_limit, hs_peak_trip, ov_trip,
                uv_trip, shutdown_temperature, sync_enable, sync_clk_in}),
    .sync_out ({ls_oc_s, neg_s, hs_trip_s, ov_s, uv_s, ot_s, sync_en_s, sync_s})
  );

  cfs_pkg::cfs_state_t state;
  cfs_pkg::cfs_state_t next_state;
  logic [cfs_pkg::TMR_W-1:0]      timer;
  logic [cfs_pkg::OC_CNT_W-1:0]   oc_cnt;
  logic [15:0]                    div_cnt;
  logic [cfs_pkg::SYNC_CNT_W-1:0] sync_cnt;
  logic [cfs_pkg::SYNC_CNT_W-1:0] prev_period;
  logic                           prev_valid;
  logic                           sync_d;
  logic                           hs_cut;
  logic                           oc_seen;
  logic                           next_hs;
  logic                           next_ls;
  logic                           switching;
  logic                           cycle_start;
  logic                           sync_fall;
  logic                           oc_event;
  logic                           sync_late;
  logic                           oc_trip3;

  // ==========================================================
  // Switching-cycle timing
  assign sync_fall   = sync_d && !sync_s;
  assign cycle_start = sync_en_s ? sync_fall : (div_cnt == PER_LAST);
  assign switching   = (state == cfs_pkg::CFS_SOFTSTART) || (state == cfs_pkg::CFS_RUN);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 16'h0000;
    end else if (div_cnt == PER_LAST) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Sync edge spacing check
  assign sync_late = sync_en_s && prev_valid &&
                     ({1'b0, sync_cnt} > ({1'b0, prev_period} + LATE));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_d      <= 1'b0;
      sync_cnt    <= 16'h0000;
      prev_period <= 16'h0000;
      prev_valid  <= 1'b0;
    end else begin
      sync_d <= sync_s;
      if (!sync_en_s) begin
        sync_cnt   <= 16'h0000;
        prev_valid <= 1'b0;
      end else if (sync_fall) begin
        sync_cnt    <= 16'h0001;
        prev_period <= sync_cnt;
        prev_valid  <= (sync_cnt != 16'h0000);
      end else if (sync_cnt != 16'h0000 && sync_cnt != 16'hFFFF) begin
        // Idle at zero until the first edge, so enable time is no period
        sync_cnt <= sync_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lost_sync_fault      <= 1'b0;
      phase_share_line_oe  <= 1'b0;
      phase_share_line_out <= 1'b0;
    end else begin
      if (!sync_en_s) begin
        lost_sync_fault <= 1'b0;
      end else if (sync_late) begin
        lost_sync_fault <= 1'b1;
      end
      phase_share_line_oe  <= lost_sync_fault;
      phase_share_line_out <= 1'b0;
    end
  end

  // ==========================================================
  // Overcurrent detection and counting
  assign oc_event = (hs_trip_s && hs_gate) || (ls_oc_s && !hs_gate);
  assign oc_trip3 = switching && cycle_start && (oc_seen || oc_event) && (oc_cnt == OC_LAST);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_seen <= 1'b0;
      hs_cut  <= 1'b0;
    end else begin
      oc_seen <= oc_event || (oc_seen && !cycle_start);
      hs_cut  <= (hs_trip_s && hs_gate) || (hs_cut && !cycle_start);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_cnt <= cfs_pkg::OC_CNT_RESET;
    end else if (!switching || oc_trip3) begin
      oc_cnt <= cfs_pkg::OC_CNT_RESET;
    end else if (cycle_start) begin
      if (oc_seen || oc_event) begin
        oc_cnt <= oc_cnt + 2'h1;
      end else begin
        oc_cnt <= cfs_pkg::OC_CNT_RESET;
      end
    end
  end

  // ==========================================================
  // Supervisor state machine, highest fault first
  always_comb begin
    next_state = state;
    if (lost_sync_fault) begin
      next_state = cfs_pkg::CFS_SYNC_LOST;
    end else if (ot_s) begin
      next_state = cfs_pkg::CFS_OT_HALT;
    end else begin
      unique case (state)
        cfs_pkg::CFS_SOFTSTART: begin
          if (ov_s) begin
            next_state = cfs_pkg::CFS_OV_DISCHARGE;
          end else if (oc_trip3) begin
            next_state = cfs_pkg::CFS_HICCUP;
          end else if (timer == SS_LAST) begin
            next_state = cfs_pkg::CFS_RUN;
          end
        end
        cfs_pkg::CFS_RUN: begin
          if (ov_s) begin
            next_state = cfs_pkg::CFS_OV_DISCHARGE;
          end else if (uv_s || oc_trip3) begin
            next_state = cfs_pkg::CFS_HICCUP;
          end
        end
        cfs_pkg::CFS_OV_DISCHARGE: begin
          if (!ov_s) begin
            next_state = cfs_pkg::CFS_HICCUP;
          end
        end
        cfs_pkg::CFS_HICCUP: begin
          if (timer == HIC_LAST) begin
            next_state = cfs_pkg::CFS_SOFTSTART;
          end
        end
        cfs_pkg::CFS_OT_HALT: begin
          next_state = cfs_pkg::CFS_SOFTSTART;
        end
        cfs_pkg::CFS_SYNC_LOST: begin
          next_state = cfs_pkg::CFS_SOFTSTART;
        end
        default: begin
          next_state = cfs_pkg::CFS_HICCUP;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cfs_pkg::CFS_SOFTSTART;
      timer <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        timer <= '0;
      end else if (timer != '1) begin
        timer <= timer + 24'h000001;
      end
    end
  end

  // ==========================================================
  // Gate drive
  always_comb begin
    next_hs = 1'b0;
    next_ls = 1'b0;
    if (state == cfs_pkg::CFS_OV_DISCHARGE) begin
      next_ls = 1'b1;
    end else if (switching && next_state == state) begin
      next_hs = pwm_on_req && !hs_cut && !(hs_trip_s && hs_gate)
                && !(!hs_gate && ls_oc_s);
      next_ls = !next_hs && !neg_s;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_gate         <= 1'b0;
      ls_gate         <= 1'b0;
      soft_start_done <= 1'b0;
      hiccup_active   <= 1'b0;
    end else begin
      hs_gate         <= next_hs;
      ls_gate         <= next_ls;
      soft_start_done <= (state == cfs_pkg::CFS_RUN);
      hiccup_active   <= (state == cfs_pkg::CFS_HICCUP);
    end
  end

  // ==========================================================
  // Assertions
  sequence s_ov_discharge;
    (state == cfs_pkg::CFS_OV_DISCHARGE) ##1 ls_gate;
  endsequence
  sequence s_uv_off;
    (state == cfs_pkg::CFS_HICCUP) ##1 (!hs_gate && !ls_gate);
  endsequence

  property p_ls_hold;
    @(posedge sys_clk) disable iff (!reset_n) (!hs_gate && ls_oc_s) |=> !hs_gate;
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("High side turned on during low-side overcurrent");

  property p_neg_limit;
    @(posedge sys_clk) disable iff (!reset_n)
      (neg_s && state != cfs_pkg::CFS_OV_DISCHARGE) |=> !ls_gate;
  endproperty
  a_neg_limit: assert property (p_neg_limit) else $error("Low side stayed on past negative limit");

  property p_oc_count;
    @(posedge sys_clk) disable iff (!reset_n)
      (switching && cycle_start && oc_event && oc_cnt < OC_LAST && next_state == state)
      |=> oc_cnt == $past(oc_cnt) + 2'h1;
  endproperty
  a_oc_count: assert property (p_oc_count) else $error("Overcurrent cycle not counted");

  property p_oc_hiccup;
    @(posedge sys_clk) disable iff (!reset_n)
      (oc_trip3 && !lost_sync_fault && !ot_s && !ov_s) |=> (state == cfs_pkg::CFS_HICCUP) && (oc_cnt == 2'h0);
  endproperty
  a_oc_hiccup: assert property (p_oc_hiccup) else $error("Third overcurrent cycle missed hiccup");

  property p_hiccup_len;
    @(posedge sys_clk) disable iff (!reset_n)
      (state == cfs_pkg::CFS_HICCUP && timer == HIC_LAST && !lost_sync_fault && !ot_s)
      |=> state == cfs_pkg::CFS_SOFTSTART;
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("Hiccup did not end in soft-start");

  property p_clean_cycle;
    @(posedge sys_clk) disable iff (!reset_n)
      (switching && cycle_start && !oc_seen && !oc_event) |=> oc_cnt == 2'h0;
  endproperty
  a_clean_cycle: assert property (p_clean_cycle) else $error("Counter not cleared by clean cycle");

  property p_hs_cut;
    @(posedge sys_clk) disable iff (!reset_n) (hs_trip_s && hs_gate) |=> (!hs_gate && hs_cut && oc_seen);
  endproperty
  a_hs_cut: assert property (p_hs_cut) else $error("Peak trip did not end on time");

  property p_ov;
    @(posedge sys_clk) disable iff (!reset_n)
      (ov_s && switching && !lost_sync_fault && !ot_s) |=> s_ov_discharge;
  endproperty
  a_ov: assert property (p_ov) else $error("Overvoltage did not discharge output");

  property p_uv;
    @(posedge sys_clk) disable iff (!reset_n)
      (uv_s && !ov_s && !ot_s && !lost_sync_fault && state == cfs_pkg::CFS_RUN) |=> s_uv_off;
  endproperty
  a_uv: assert property (p_uv) else $error("Undervoltage did not force switches off");

  property p_ot;
    @(posedge sys_clk) disable iff (!reset_n)
      (ot_s && !lost_sync_fault) |=> (state == cfs_pkg::CFS_OT_HALT) ##1 (!hs_gate && !ls_gate);
  endproperty
  a_ot: assert property (p_ot) else $error("Over-temperature did not halt");

  property p_lost_sync;
    @(posedge sys_clk) disable iff (!reset_n)
      sync_late |=> lost_sync_fault ##1 (phase_share_line_oe && !phase_share_line_out);
  endproperty
  a_lost_sync: assert property (p_lost_sync) else $error("Late sync edge did not pull share line");
endmodule
`default_nettype wire

/* File: tb/cfs_partner.sv */
// Purpose: External sync clock source facing the supervisor
// Assumes: Period not longer than the internal switching period
// Notes:   Clock stands still high while run is low
`timescale 1ns/10ps
`default_nettype none
module cfs_partner #(
  parameter int HALF_NS = 95
) (
  // Control
  input  wire logic run,
  // Sync pin
  output var  logic sync_clk_in
);
  // ==========================================
  // Free phase clock, faster than internal rate
  // Small offset keeps pin edges off the bench clock edges
  initial begin
    sync_clk_in = 1'b1;
    #2;
    forever begin
      #(HALF_NS);
      if (run) begin
        sync_clk_in = ~sync_clk_in;
      end else begin
        sync_clk_in = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/converter_fault_supervisor_bench.sv */
// Purpose: Self-checking bench for the converter fault supervisor
// Assumes: Shortened soft-start and switching period
// Notes:   Inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module converter_fault_supervisor_bench;
  localparam int SS  = 20;
  localparam int PER = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pwm_on_req = 1'b0;
  logic ls_overcurrent = 1'b0;
  logic neg_current_limit = 1'b0;
  logic hs_peak_trip = 1'b0;
  logic ov_trip = 1'b0;
  logic uv_trip = 1'b0;
  logic shutdown_temperature = 1'b0;
  logic sync_enable = 1'b0;
  logic sync_run = 1'b0;
  logic sync_clk_in;
  logic hs_gate, ls_gate, phase_share_line_out, phase_share_line_oe;
  logic soft_start_done, hiccup_active, lost_sync_fault;
  logic p;
  int   n_mismatch = 0;
  int   cmp_count = 0;
  int   seed = 29;

  always #5 sys_clk = ~sys_clk;

  cfs_supervisor #(.SS_CYCLES(SS), .PERIOD_CYC(PER)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .pwm_on_req(pwm_on_req),
    .ls_overcurrent(ls_overcurrent), .neg_current_limit(neg_current_limit),
    .hs_peak_trip(hs_peak_trip), .ov_trip(ov_trip), .uv_trip(uv_trip),
    .shutdown_temperature(shutdown_temperature), .sync_enable(sync_enable),
    .sync_clk_in(sync_clk_in), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .phase_share_line_out(phase_share_line_out), .phase_share_line_oe(phase_share_line_oe),
    .soft_start_done(soft_start_done), .hiccup_active(hiccup_active),
    .lost_sync_fault(lost_sync_fault));

  cfs_partner partner_u (.run(sync_run), .sync_clk_in(sync_clk_in));

  // ==========================================
  // Helpers
  function automatic int hiccup_len();
    return cfs_pkg::HICCUP_SS_MULT * SS;
  endfunction
  function automatic logic exp_ls(input logic hs, input logic neg);
    return !hs && !neg;
  endfunction
  function automatic logic get(input int sel);
    case (sel)
      0: return soft_start_done;
      1: return hiccup_active;
      2: return lost_sync_fault;
      default: return hs_gate;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_sig(input int sel, input logic val, input int lim);
    int k;
    k = 0;
    while (get(sel) !== val && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(get(sel), val)
  endtask
  task automatic oc_event();
    wait_sig(3, 1'b1, 40);
    hs_peak_trip = 1'b1;
    wait_sig(3, 1'b0, 6);
    hs_peak_trip = 1'b0;
  endtask
  task automatic clean_cycle();
    wait_sig(3, 1'b1, 40);
    cyc(PER + 3);
  endtask
  task automatic recover();
    wait_sig(1, 1'b0, hiccup_len() + 20);
    wait_sig(0, 1'b1, SS + 15);
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    cyc(30000);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================
  // Main sequence
  initial begin
    cyc(8);
    reset_n = 1'b1;
    wait_sig(0, 1'b1, SS + 15);
    // Random modulator requests, clean run
    repeat (40) begin
      p = 1'($random(seed));
      pwm_on_req = p;
      cyc(1);
      `CHK(hs_gate, p)
      `CHK(ls_gate, exp_ls(p, 1'b0))
    end
    pwm_on_req = 1'b0;
    cyc(4);
    `CHK(ls_gate, 1'b1)
    neg_current_limit = 1'b1;
    cyc(5);
    `CHK(ls_gate, 1'b0)
    neg_current_limit = 1'b0;
    cyc(5);
    // Low-side overcurrent holds off state, then hiccup
    ls_overcurrent = 1'b1;
    cyc(3);
    pwm_on_req = 1'b1;
    cyc(5);
    `CHK(hs_gate, 1'b0)
    wait_sig(1, 1'b1, 3 * PER + 10);
    cyc(hiccup_len() - 5);
    `CHK(hiccup_active, 1'b1)
    wait_sig(1, 1'b0, 15);
    wait_sig(1, 1'b1, SS + 4 * PER);
    ls_overcurrent = 1'b0;
    recover();
    // Peak trips, clean cycles clear the count
    repeat (2) oc_event();
    clean_cycle();
    repeat (2) oc_event();
    clean_cycle();
    `CHK(hiccup_active, 1'b0)
    repeat (3) oc_event();
    wait_sig(1, 1'b1, PER + 10);
    recover();
    // Overvoltage discharge then hiccup
    ov_trip = 1'b1;
    cyc(6);
    `CHK(ls_gate, 1'b1)
    `CHK(hs_gate, 1'b0)
    ov_trip = 1'b0;
    wait_sig(1, 1'b1, 8);
    cyc(3);
    `CHK(ls_gate, 1'b0)
    wait_sig(1, 1'b0, hiccup_len() + 20);
    // Undervoltage ignored until soft-start ends
    uv_trip = 1'b1;
    wait_sig(0, 1'b1, SS + 15);
    wait_sig(1, 1'b1, 8);
    cyc(3);
    `CHK(hs_gate, 1'b0)
    `CHK(ls_gate, 1'b0)
    uv_trip = 1'b0;
    cyc(hiccup_len() - 20);
    `CHK(hiccup_active, 1'b1)
    recover();
    // Over-temperature halt and restart
    shutdown_temperature = 1'b1;
    cyc(56);
    `CHK(hs_gate, 1'b0)
    `CHK(soft_start_done, 1'b0)
    shutdown_temperature = 1'b0;
    wait_sig(0, 1'b1, SS + 15);
    // Sync loss
    sync_enable = 1'b1;
    sync_run = 1'b1;
    cyc(300);
    `CHK(lost_sync_fault, 1'b0)
    `CHK(hs_gate, 1'b1)
    sync_run = 1'b0;
    cyc(90);
    `CHK(lost_sync_fault, 1'b0)
    wait_sig(2, 1'b1, 50);
    cyc(2);
    `CHK(phase_share_line_oe, 1'b1)
    `CHK(phase_share_line_out, 1'b0)
    `CHK(hs_gate, 1'b0)
    sync_enable = 1'b0;
    wait_sig(2, 1'b0, 8);
    wait_sig(0, 1'b1, SS + 15);
    give_verdict();
  end
endmodule
`default_nettype wire
